// ---- common/usb_pkg.sv ----
package usb_pkg;

	// register byte offsets on the axi4-lite slave
	localparam logic [5:0] OFF_DIV_LOW  = 6'h00;
	localparam logic [5:0] OFF_DIV_HIGH = 6'h04;
	localparam logic [5:0] OFF_IER      = 6'h08;
	localparam logic [5:0] OFF_LCR      = 6'h0c;
	localparam logic [5:0] OFF_MCR      = 6'h10;
	localparam logic [5:0] OFF_EFR      = 6'h14;
	localparam logic [5:0] OFF_STATUS   = 6'h18;
	localparam logic [5:0] OFF_CHARLEN  = 6'h1c;

	// field positions
	localparam int EFR_ENH_BIT   = 4;
	localparam int IER_SLEEP_BIT = 4;
	localparam int LCR_BREAK_BIT = 6;
	localparam int MCR_PRESC_BIT = 7;

	// reset values
	localparam logic [7:0] IER_RESET     = 8'h00;
	localparam logic [7:0] LCR_RESET     = 8'h1d;
	localparam logic [7:0] MCR_RESET     = 8'h00;
	localparam logic [7:0] EFR_RESET     = 8'h00;
	localparam logic [3:0] CHARLEN_RESET = 4'h8;

	// timing figures
	localparam int PRESC_RATIO    = 4;
	localparam int OVERSAMPLE     = 16;
	localparam int IDLE_CHAR_MULT = 4;
	localparam int IDLE_EXTRA     = 12;
	localparam int MID_SAMPLE     = OVERSAMPLE / 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		USB_AWAKE  = 2'b01,
		USB_ASLEEP = 2'b10
	} usb_state_t;

	typedef struct packed {
		logic rx_fifo_empty;
		logic tx_fifo_empty;
		logic tx_shift_empty;
		logic other_irq_pending;
		logic modem_change;
		logic tx_fifo_write;
	} usb_sleep_in_t;

endpackage

// ---- hdl/usb_baud_gen.sv ----
`timescale 1ns/1ps

module usb_baud_gen
	import usb_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             run,
	input  wire logic             presc_sel,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  baud16_en
);

	initial begin
		if (DIV_W < 2) $error("usb_baud_gen: DIV_W too small");
	end

	logic [1:0]       presc_cnt;
	logic [1:0]       next_presc_cnt;
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic             next_baud16_en;
	logic             presc_tick;

	always_comb begin
		next_presc_cnt = presc_cnt;
		next_div_cnt   = div_cnt;
		next_baud16_en = 1'b0;
		presc_tick     = 1'b0;
		if (run && divisor != '0) begin
			if (presc_sel) begin
				presc_tick     = (presc_cnt == 2'(PRESC_RATIO - 1));
				next_presc_cnt = presc_tick ? 2'h0 : presc_cnt + 2'h1;
			end else begin
				presc_tick     = 1'b1;
				next_presc_cnt = 2'h0;
			end
			if (presc_tick) begin
				if (div_cnt >= divisor - 1'b1) begin
					next_div_cnt   = '0;
					next_baud16_en = 1'b1;
				end else begin
					next_div_cnt = div_cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_cnt <= 2'h0;
			div_cnt   <= '0;
			baud16_en <= 1'b0;
		end else begin
			presc_cnt <= next_presc_cnt;
			div_cnt   <= next_div_cnt;
			baud16_en <= next_baud16_en;
		end
	end

endmodule

// ---- hdl/usb_uart_sleep_baud.sv ----
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module usb_uart_sleep_baud
	import usb_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [5:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [5:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          rx_pin,
	input  wire logic [3:0]    modem_pins,
	input  wire usb_sleep_in_t sleep_in,
	output logic               tx_pin,
	input  wire logic          tx_data,
	output logic               uart_clk_en,
	output logic               baud16_en,
	output logic               rx_sample_en,
	output logic               rx_sample,
	output logic               asleep
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] div_low;
	logic [7:0] div_high;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] line_control_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] enhanced_feature_reg;
	logic [3:0] char_len;
	logic [7:0] next_div_low;
	logic [7:0] next_div_high;
	logic [7:0] next_ier;
	logic [7:0] next_lcr;
	logic [7:0] next_mcr;
	logic [7:0] next_efr;
	logic [3:0] next_char_len;

	logic        aw_held;
	logic        w_held;
	logic [5:0]  aw_addr;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        next_aw_held;
	logic        next_w_held;
	logic [5:0]  next_aw_addr;
	logic [7:0]  next_w_byte;
	logic        next_w_lane0;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        do_write;
	logic        wr_ok;
	logic        rd_ok;

	function automatic logic addr_mapped(input logic [5:0] a);
		addr_mapped = (a[1:0] == 2'h0) && (a <= OFF_CHARLEN);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sleep, wake and rx idle

	logic [2:0]  rx_sync;
	logic [3:0]  modem_s1;
	logic [3:0]  modem_s2;
	logic [3:0]  modem_prev;
	logic        rx_prev;
	usb_state_t  state;
	usb_state_t  next_state;
	logic [3:0]  os_cnt;
	logic [3:0]  next_os_cnt;
	logic [5:0]  idle_bits;
	logic [5:0]  next_idle_bits;
	logic        rx_idle;
	logic        next_rx_idle;
	logic        next_rx_sample_en;
	logic        next_rx_sample;
	logic        next_tx_pin;
	logic        sleep_enabled;
	logic        sleep_ok;
	logic        wake;
	logic        gen_tick;
	logic [5:0]  idle_limit;

	// only a completed handshake counts, so a held but unaccepted address is never used
	assign do_write      = (aw_held || (s_axi_awvalid && s_axi_awready))
		&& (w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
	assign wr_ok         = addr_mapped(aw_held ? aw_addr : s_axi_awaddr);
	assign rd_ok         = addr_mapped(s_axi_araddr);
	assign sleep_enabled = enhanced_feature_reg[EFR_ENH_BIT] && interrupt_enable_reg[IER_SLEEP_BIT];
	assign idle_limit    = 6'(IDLE_CHAR_MULT) * {2'h0, char_len} + 6'(IDLE_EXTRA);
	assign wake = (rx_sync[2] != rx_prev) || (modem_s2 != modem_prev)
		|| sleep_in.tx_fifo_write;
	assign sleep_ok = sleep_enabled && rx_idle && sleep_in.tx_fifo_empty
		&& sleep_in.tx_shift_empty && !sleep_in.other_irq_pending
		&& sleep_in.rx_fifo_empty;

	// divisor writes during sleep are refused by host discipline only
	usb_baud_gen #(
		.DIV_W (16)
	) u_baud (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (state == USB_AWAKE),
		.presc_sel (modem_control_reg[MCR_PRESC_BIT]),
		.divisor   ({div_high, div_low}),
		.baud16_en (gen_tick)
	);

	always_comb begin
		next_div_low  = div_low;
		next_div_high = div_high;
		next_ier      = interrupt_enable_reg;
		next_lcr      = line_control_reg;
		next_mcr      = modem_control_reg;
		next_efr      = enhanced_feature_reg;
		next_char_len = char_len;
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_byte   = w_byte;
		next_w_lane0  = w_lane0;
		next_bvalid   = s_axi_bvalid && !s_axi_bready;
		next_bresp    = s_axi_bresp;
		next_rvalid   = s_axi_rvalid && !s_axi_rready;
		next_rdata    = s_axi_rdata;
		next_rresp    = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
			if (w_held ? w_lane0 : s_axi_wstrb[0]) begin
				case (aw_held ? aw_addr : s_axi_awaddr)
					OFF_DIV_LOW:  next_div_low  = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_DIV_HIGH: next_div_high = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_IER:      next_ier      = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_LCR:      next_lcr      = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_MCR:      next_mcr      = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_EFR:      next_efr      = w_held ? w_byte : s_axi_wdata[7:0];
					OFF_CHARLEN:  next_char_len = w_held ? w_byte[3:0] : s_axi_wdata[3:0];
					default:      next_efr      = enhanced_feature_reg;
				endcase
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFF_DIV_LOW:  next_rdata = {24'h0, div_low};
				OFF_DIV_HIGH: next_rdata = {24'h0, div_high};
				OFF_IER:      next_rdata = {24'h0, interrupt_enable_reg};
				OFF_LCR:      next_rdata = {24'h0, line_control_reg};
				OFF_MCR:      next_rdata = {24'h0, modem_control_reg};
				OFF_EFR:      next_rdata = {24'h0, enhanced_feature_reg};
				OFF_STATUS:   next_rdata = {29'h0, sleep_ok, rx_idle, state == USB_ASLEEP};
				OFF_CHARLEN:  next_rdata = {28'h0, char_len};
				default:      next_rdata = 32'h0;
			endcase
		end
	end

	// divisor bytes sit outside the reset branch so reset keeps them
	always_ff @(posedge aclk) begin
		div_low  <= next_div_low;
		div_high <= next_div_high;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable_reg           <= IER_RESET;
			line_control_reg           <= LCR_RESET;
			modem_control_reg           <= MCR_RESET;
			enhanced_feature_reg           <= EFR_RESET;
			char_len      <= CHARLEN_RESET;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 6'h00;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			interrupt_enable_reg           <= next_ier;
			line_control_reg           <= next_lcr;
			modem_control_reg           <= next_mcr;
			enhanced_feature_reg           <= next_efr;
			char_len      <= next_char_len;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_byte        <= next_w_byte;
			w_lane0       <= next_w_lane0;
			s_axi_awready <= !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep state, rx sampling and idle count

	always_comb begin
		next_state        = state;
		next_os_cnt       = os_cnt;
		next_idle_bits    = idle_bits;
		next_rx_idle      = rx_idle;
		next_rx_sample_en = 1'b0;
		next_rx_sample    = rx_sample;
		next_tx_pin       = line_control_reg[LCR_BREAK_BIT] ? 1'b0 : tx_data;
		case (state)
			USB_AWAKE: begin
				if (sleep_ok && !wake) begin
					next_state = USB_ASLEEP;
				end
			end
			USB_ASLEEP: begin
				// clocks restart first; the wake event is acted on next cycle
				if (wake || !sleep_enabled) begin
					next_state = USB_AWAKE;
				end
			end
			default: next_state = USB_AWAKE;
		endcase
		if (rx_sync[2] != rx_prev || !rx_sync[2]) begin
			next_idle_bits = 6'h00;
			next_rx_idle   = 1'b0;
			next_os_cnt    = 4'h0;
		end else if (gen_tick && next_state == USB_AWAKE) begin
			next_os_cnt = os_cnt + 4'h1;
			if (os_cnt == 4'(MID_SAMPLE - 1)) begin
				next_rx_sample_en = 1'b1;
				next_rx_sample    = rx_sync[2];
				if (idle_bits >= idle_limit - 6'h1) begin
					next_rx_idle = 1'b1;
				end else begin
					next_idle_bits = idle_bits + 6'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sync      <= 3'h7;
			modem_s1     <= 4'h0;
			modem_s2     <= 4'h0;
			modem_prev   <= 4'h0;
			rx_prev      <= 1'b1;
			state        <= USB_AWAKE;
			os_cnt       <= 4'h0;
			idle_bits    <= 6'h00;
			rx_idle      <= 1'b0;
			rx_sample_en <= 1'b0;
			rx_sample    <= 1'b1;
			tx_pin       <= 1'b1;
			uart_clk_en  <= 1'b1;
			baud16_en    <= 1'b0;
			asleep       <= 1'b0;
		end else begin
			rx_sync      <= {rx_sync[1], rx_sync[0], rx_pin};
			modem_s1     <= modem_pins;
			modem_s2     <= modem_s1;
			modem_prev   <= modem_s2;
			rx_prev      <= rx_sync[2];
			state        <= next_state;
			os_cnt       <= next_os_cnt;
			idle_bits    <= next_idle_bits;
			rx_idle      <= next_rx_idle;
			rx_sample_en <= next_rx_sample_en;
			rx_sample    <= next_rx_sample;
			tx_pin       <= next_tx_pin;
			uart_clk_en  <= (next_state == USB_AWAKE);
			// the generator's last tick can land in the entry cycle; mask it
			baud16_en    <= gen_tick && (next_state == USB_AWAKE);
			asleep       <= (next_state == USB_ASLEEP);
		end
	end

endmodule

// ---- dv/usb_peer.sv ----
`timescale 1ns/1ps
module usb_peer (
	input  wire logic aclk,
	input  wire logic hold_low,
	input  wire logic flip_modem,
	output logic      rx_pin,
	output logic [3:0] modem_pins
);
	// pull-up on the line: a released line reads high, never the last bit
	assign rx_pin = !hold_low;
	initial modem_pins = 4'h0;
	always @(posedge aclk) begin
		if (flip_modem) begin
			modem_pins <= modem_pins ^ 4'h1;
		end
	end
endmodule

// ---- dv/usb_sleep_checker.sv ----
`timescale 1ns/1ps
module usb_sleep_checker
	import usb_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          rx_pin,
	input wire logic [3:0]    modem_pins,
	input wire usb_sleep_in_t sleep_in,
	input wire logic          tx_pin,
	input wire logic          tx_data,
	input wire logic          uart_clk_en,
	input wire logic          baud16_en,
	input wire logic          rx_sample_en,
	input wire logic          asleep
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic drained;
	// folded into one net so $past sees a plain signal
	assign drained = sleep_in.tx_fifo_empty && sleep_in.tx_shift_empty
		&& !sleep_in.other_irq_pending;
	////////////////////////////////////////////////////////////////
	clk_gate_a: assert property (asleep |-> !uart_clk_en)
		else $error("clock enable high while asleep");
	baud_gate_a: assert property (asleep |-> !baud16_en)
		else $error("baud tick while asleep");
	fifo_block_a: assert property ($rose(asleep) |-> $past(sleep_in.rx_fifo_empty))
		else $error("slept with receive data held");
	entry_cond_a: assert property ($rose(asleep) |-> $past(drained))
		else $error("slept while transmit busy or irq pending");
	wake_write_a: assert property (asleep && sleep_in.tx_fifo_write |-> ##[1:3] !asleep)
		else $error("no wake on fifo write");
	wake_modem_a: assert property (asleep && $changed(modem_pins) |-> ##[1:5] !asleep)
		else $error("no wake on modem change");
	wake_rx_a: assert property (asleep && $changed(rx_pin) |-> ##[1:6] !asleep)
		else $error("no wake on rx change");
	mid_sample_a: assert property (rx_sample_en |-> baud16_en || $past(baud16_en))
		else $error("rx sample off the baud tick");
	tx_follow_a: assert property (tx_pin |-> $past(tx_data))
		else $error("tx high without transmit data");
	cover property ($rose(asleep));
	cover property ($fell(asleep));
	cover property (rx_sample_en);
endmodule
bind usb_uart_sleep_baud usb_sleep_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.rx_pin(rx_pin), .modem_pins(modem_pins), .sleep_in(sleep_in), .tx_pin(tx_pin),
	.tx_data(tx_data), .uart_clk_en(uart_clk_en), .baud16_en(baud16_en),
	.rx_sample_en(rx_sample_en), .asleep(asleep));

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import usb_pkg::*;
	logic          aclk = 1'h0, aresetn = 1'h0;
	logic [5:0]    awaddr = 6'h00, araddr = 6'h00;
	logic [31:0]   wdata = 32'h0, rdata, rv;
	logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic          rready = 1'h0, tx_data = 1'h1, hold_low = 1'h0, flip_modem = 1'h0;
	usb_sleep_in_t sin = '0;
	logic          awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin;
	logic          clk_en, b16, smp_en, smp, asleep;
	logic [1:0]    bresp, rresp, rr;
	logic [3:0]    mdm;
	int            miscompares = 0, checked = 0, n, p, e;
	always #4 aclk = ~aclk;
	usb_uart_sleep_baud dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_pin(rx_pin), .modem_pins(mdm), .sleep_in(sin),
		.tx_pin(tx_pin), .tx_data(tx_data), .uart_clk_en(clk_en), .baud16_en(b16),
		.rx_sample_en(smp_en), .rx_sample(smp), .asleep(asleep));
	usb_peer peer (.aclk(aclk), .hold_low(hold_low), .flip_modem(flip_modem),
		.rx_pin(rx_pin), .modem_pins(mdm));
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task stall;
		miscompares++;
		$display("BAD wait expected answer seen none");
		report_and_stop;
	endtask
	// both channels offered together, each dropped once its own ready is seen
	task wr(input logic [5:0] a, input logic [7:0] d);
		int i;
		i = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			i++;
		end while (bvalid !== 1'h1 && i < 100);
		bready <= 1'h0;
		@(posedge aclk);
		if (i >= 100) stall;
	endtask
	task rd(input logic [5:0] a);
		int i;
		i = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			i++;
		end while (rvalid !== 1'h1 && i < 100);
		rv = rdata;
		rr = rresp;
		rready <= 1'h0;
		@(posedge aclk);
		if (i >= 100) stall;
	endtask
	task wait_sleep(input logic v, input int lim);
		n = 0;
		while (asleep !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
		if (n >= lim) stall;
	endtask
	// gap between two baud ticks; called twice so a divisor change settles
	task period;
		n = 0;
		while (b16 !== 1'h1 && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		p = 0;
		do begin
			@(posedge aclk);
			p++;
		end while (b16 !== 1'h1 && p < 2000);
		if (n >= 2000 || p >= 2000) stall;
	endtask
	task stay_awake(input string nm);
		repeat (1200) @(posedge aclk);
		chk(nm, asleep, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [5:0]  ra [5];
		logic [7:0]  rz [5];
		logic [23:0] tbl [5];
		ra = '{OFF_IER, OFF_LCR, OFF_MCR, OFF_EFR, OFF_CHARLEN};
		rz = '{IER_RESET, LCR_RESET, MCR_RESET, EFR_RESET, {4'h0, CHARLEN_RESET}};
		tbl = '{24'h01_00_00, 24'h0c_00_00, 24'h60_00_00, 24'h00_01_00, 24'h03_00_80};
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int k = 0; k < 5; k++) begin
			rd(ra[k]);
			chk("reset value", rv, {24'h0, rz[k]});
		end
		rd(6'h3c);
		chk("unmapped resp", rr, RESP_SLVERR);
		$display("test registers done");
		for (int k = 0; k < 5; k++) begin
			wr(OFF_DIV_LOW, tbl[k][23:16]);
			wr(OFF_DIV_HIGH, tbl[k][15:8]);
			wr(OFF_MCR, tbl[k][7:0]);
			e = {tbl[k][15:8], tbl[k][23:16]} * (tbl[k][7] ? PRESC_RATIO : 1);
			period;
			period;
			chk("baud period", p, e);
		end
		wr(OFF_DIV_LOW, 8'h00);
		repeat (20) @(posedge aclk);
		n = 0;
		repeat (300) begin
			@(posedge aclk);
			n += int'(b16 === 1'h1);
		end
		chk("zero divisor ticks", n, 0);
		wr(OFF_DIV_LOW, 8'ha5);
		wr(OFF_DIV_HIGH, 8'h01);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(OFF_DIV_LOW);
		chk("divisor after reset", rv, 32'h0000_00a5);
		period;
		period;
		chk("undivided after reset", p, 421);
		$display("test baud done");
		wr(OFF_LCR, LCR_RESET | (8'h01 << LCR_BREAK_BIT));
		repeat (3) @(posedge aclk);
		chk("break level", tx_pin, 1'h0);
		wr(OFF_LCR, LCR_RESET);
		repeat (3) @(posedge aclk);
		chk("break released", tx_pin, 1'h1);
		tx_data <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("tx follows data", tx_pin, 1'h0);
		tx_data <= 1'h1;
		repeat (3) @(posedge aclk);
		$display("test break done");
		wr(OFF_DIV_LOW, 8'h01);
		wr(OFF_DIV_HIGH, 8'h00);
		wr(OFF_CHARLEN, 8'h05);
		sin.tx_fifo_empty <= 1'h1;
		sin.tx_shift_empty <= 1'h1;
		sin.rx_fifo_empty <= 1'h1;
		wr(OFF_EFR, 8'h01 << EFR_ENH_BIT);
		stay_awake("enhanced only");
		sin.rx_fifo_empty <= 1'h0;
		wr(OFF_IER, 8'h01 << IER_SLEEP_BIT);
		stay_awake("rx fifo held");
		sin.rx_fifo_empty <= 1'h1;
		sin.other_irq_pending <= 1'h1;
		stay_awake("irq pending");
		hold_low <= 1'h1;
		repeat (32) @(posedge aclk);
		hold_low <= 1'h0;
		sin.other_irq_pending <= 1'h0;
		wait_sleep(1'h1, 2000);
		e = (IDLE_CHAR_MULT * 5 + IDLE_EXTRA) * OVERSAMPLE;
		chk("idle time", n >= e - 16 && n <= e + 48, 1'h1);
		chk("rx sample level", smp, 1'h1);
		for (int k = 0; k < 3; k++) begin
			wait_sleep(1'h1, 2000);
			chk("gated clock", clk_en, 1'h0);
			sin.tx_fifo_write <= (k == 0);
			flip_modem <= (k == 1);
			hold_low <= (k == 2);
			@(posedge aclk);
			sin.tx_fifo_write <= 1'h0;
			flip_modem <= 1'h0;
			wait_sleep(1'h0, 10);
			chk("clock restart", clk_en, 1'h1);
			hold_low <= 1'h0;
		end
		wr(OFF_IER, 8'h00);
		stay_awake("sleep disabled");
		$display("test sleep done");
		report_and_stop;
	end
endmodule
